// *** inc/pjafm_pkg.sv ***
package pjafm_pkg;

  localparam int PIN_COUNT = 7;
  localparam int PLANE_LINES = 40;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int SYNC_STAGES = 3;

  // register offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h1;
  localparam logic [3:0] ADDR_PIN_STAT = 4'h2;
  localparam logic [3:0] ADDR_OVR_STAT = 4'h3;
  localparam logic [3:0] ADDR_LINK_STAT = 4'h4;

  // control register field positions
  localparam int CTRL_LCD_EN_BIT = 0;
  localparam int CTRL_LCD_PM_BIT = 1;
  localparam int CTRL_PCG_EN0_BIT = 2;
  localparam int CTRL_PUD_BIT = 3;
  localparam int CTRL_W = 4;

  // values after reset
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [6:0] MASK_RESET = 7'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // pin n is pin-change source PCINT_BASE + n
  localparam int PCINT_BASE = 24;
  // front-plane line taken by pin n, index 0 is bit 0
  localparam int PLANE_MAP [0:6] = '{35, 34, 31, 30, 29, 28, 27};

  // fixed override values while the lcd owns the pins
  localparam logic PU_OVR_VAL = 1'b0;
  localparam logic DIR_OVR_VAL = 1'b0;
  localparam logic PV_OVR_EN = 1'b0;
  localparam logic PV_OVR_VAL = 1'b0;
  localparam logic IE_OVR_VAL = 1'b1;

  typedef struct packed {
    logic global_pullup_disable;
    logic pin_change_group_enable_0;
    logic lcd_power_mode;
    logic lcd_enable;
  } pjafm_ctrl_t;

  typedef struct packed {
    logic [6:0] drive_en;
    logic [6:0] drive_val;
    logic [6:0] pullup_en;
  } pjafm_pad_t;

  typedef struct packed {
    logic [6:0] pullup_override_enable;
    logic [6:0] pullup_override_value;
    logic [6:0] direction_override_enable;
    logic [6:0] direction_override_value;
    logic [6:0] port_value_override_enable;
    logic [6:0] port_value_override_value;
    logic [6:0] input_enable_override_enable;
    logic [6:0] input_enable_override_value;
  } pjafm_ovr_t;

endpackage

// *** hw/pjafm_sync.sv ***
`timescale 1ns/1ns
module pjafm_sync #(
  parameter int WIDTH = 7
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] stable_out
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // s1 feeds only s2 to keep metastability contained
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a change counts once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          stable_out[i] <= 1'b0;
        end else if (s2_reg[i] == s3_reg[i]) begin
          stable_out[i] <= s3_reg[i];
        end
      end
    end
  endgenerate

endmodule

// *** hw/pjafm_mux.sv ***
`timescale 1ns/1ns
module pjafm_mux #(
  parameter int PINS = pjafm_pkg::PIN_COUNT
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [6:0] port_dir,
  input wire logic [6:0] port_out,
  input wire logic [6:0] port_input_enable,
  input wire logic [6:0] pad_in,
  input wire logic [39:0] lcd_front_plane_out,
  output pjafm_pkg::pjafm_pad_t pad,
  output pjafm_pkg::pjafm_ovr_t ovr,
  output logic [6:0] analog_pin_link,
  output logic [6:0] analog_link_en,
  output logic [6:0] digital_in,
  output logic [6:0] pin_change_src
);

  pjafm_pkg::pjafm_ctrl_t ctrl_reg;
  logic [6:0] mask_reg;
  logic [6:0] pin_stable;
  logic [6:0] ie_oe;
  logic [6:0] din_next;
  logic [7:0] rdata_next;

  pjafm_sync #(
    .WIDTH(PINS)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(pad_in),
    .stable_out(pin_stable)
  );

  // control and mask registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= pjafm_pkg::CTRL_RESET;
    end else if (reg_wr && reg_addr == pjafm_pkg::ADDR_CTRL) begin
      ctrl_reg.lcd_enable <= reg_wdata[pjafm_pkg::CTRL_LCD_EN_BIT];
      ctrl_reg.lcd_power_mode <= reg_wdata[pjafm_pkg::CTRL_LCD_PM_BIT];
      ctrl_reg.pin_change_group_enable_0 <= reg_wdata[pjafm_pkg::CTRL_PCG_EN0_BIT];
      ctrl_reg.global_pullup_disable <= reg_wdata[pjafm_pkg::CTRL_PUD_BIT];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mask_reg <= pjafm_pkg::MASK_RESET;
    end else if (reg_wr && reg_addr == pjafm_pkg::ADDR_MASK) begin
      mask_reg <= reg_wdata[6:0];
    end
  end

  // read data stand one cycle, zero otherwise and for unmapped offsets
  always_comb begin
    rdata_next = pjafm_pkg::RDATA_RESET;
    if (reg_rd) begin
      unique case (reg_addr)
        pjafm_pkg::ADDR_CTRL: rdata_next = {4'h0, ctrl_reg.global_pullup_disable,
            ctrl_reg.pin_change_group_enable_0, ctrl_reg.lcd_power_mode, ctrl_reg.lcd_enable};
        pjafm_pkg::ADDR_MASK: rdata_next = {1'b0, mask_reg};
        pjafm_pkg::ADDR_PIN_STAT: rdata_next = {1'b0, digital_in};
        pjafm_pkg::ADDR_OVR_STAT: rdata_next = {1'b0, ovr.input_enable_override_enable};
        pjafm_pkg::ADDR_LINK_STAT: rdata_next = {1'b0, analog_pin_link};
        default: rdata_next = pjafm_pkg::RDATA_RESET;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= pjafm_pkg::RDATA_RESET;
    end else begin
      reg_rdata <= rdata_next;
    end
  end

  genvar i;
  generate
    for (i = 0; i < PINS; i++) begin : g_pin
      assign ie_oe[i] = mask_reg[i] & ctrl_reg.pin_change_group_enable_0 &
                        ctrl_reg.lcd_enable & ctrl_reg.lcd_power_mode;
      // input kept alive while overridden so pin changes still wake the part
      assign din_next[i] = (ie_oe[i] ? pjafm_pkg::IE_OVR_VAL : port_input_enable[i]) &
                           pin_stable[i];

      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          pad.drive_en[i] <= 1'b0;
          pad.drive_val[i] <= 1'b0;
        end else begin
          pad.drive_en[i] <= ctrl_reg.lcd_enable ? pjafm_pkg::DIR_OVR_VAL : port_dir[i];
          pad.drive_val[i] <= port_out[i];
        end
      end

      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          pad.pullup_en[i] <= 1'b0;
        end else if (ctrl_reg.lcd_enable || ctrl_reg.global_pullup_disable) begin
          pad.pullup_en[i] <= pjafm_pkg::PU_OVR_VAL;
        end else begin
          pad.pullup_en[i] <= ~port_dir[i] & port_out[i];
        end
      end

      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          ovr.pullup_override_enable[i] <= 1'b0;
          ovr.pullup_override_value[i] <= 1'b0;
          ovr.direction_override_enable[i] <= 1'b0;
          ovr.direction_override_value[i] <= 1'b0;
          ovr.port_value_override_enable[i] <= 1'b0;
          ovr.port_value_override_value[i] <= 1'b0;
          ovr.input_enable_override_enable[i] <= 1'b0;
          ovr.input_enable_override_value[i] <= 1'b0;
        end else begin
          ovr.pullup_override_enable[i] <= ctrl_reg.lcd_enable;
          ovr.pullup_override_value[i] <= pjafm_pkg::PU_OVR_VAL;
          ovr.direction_override_enable[i] <= ctrl_reg.lcd_enable;
          ovr.direction_override_value[i] <= pjafm_pkg::DIR_OVR_VAL;
          ovr.port_value_override_enable[i] <= pjafm_pkg::PV_OVR_EN;
          ovr.port_value_override_value[i] <= pjafm_pkg::PV_OVR_VAL;
          ovr.input_enable_override_enable[i] <= ie_oe[i];
          ovr.input_enable_override_value[i] <= pjafm_pkg::IE_OVR_VAL;
        end
      end

      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          analog_pin_link[i] <= 1'b0;
          analog_link_en[i] <= 1'b0;
          digital_in[i] <= 1'b0;
          pin_change_src[i] <= 1'b0;
        end else begin
          analog_pin_link[i] <= lcd_front_plane_out[pjafm_pkg::PLANE_MAP[i]];
          analog_link_en[i] <= ctrl_reg.lcd_enable;
          digital_in[i] <= din_next[i];
          pin_change_src[i] <= din_next[i];
        end
      end
    end
  endgenerate

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_bit6_route_map: assert property (
    analog_pin_link[6] == $past(lcd_front_plane_out[pjafm_pkg::PLANE_MAP[6]]) &&
    (pin_change_src[6] == $past(din_next[6])))
    else $error("bit 6 routing wrong");

  a_bit5_route_map: assert property (
    analog_pin_link[5] == $past(lcd_front_plane_out[pjafm_pkg::PLANE_MAP[5]]) &&
    (pin_change_src[5] == $past(din_next[5])))
    else $error("bit 5 routing wrong");

  a_bit4_route_map: assert property (
    analog_pin_link[4] == $past(lcd_front_plane_out[pjafm_pkg::PLANE_MAP[4]]) &&
    (pin_change_src[4] == $past(din_next[4])))
    else $error("bit 4 routing wrong");

  a_bit3_route_map: assert property (
    analog_pin_link[3] == $past(lcd_front_plane_out[pjafm_pkg::PLANE_MAP[3]]) &&
    (pin_change_src[3] == $past(din_next[3])))
    else $error("bit 3 routing wrong");

  a_bit2_route_map: assert property (
    analog_pin_link[2] == $past(lcd_front_plane_out[pjafm_pkg::PLANE_MAP[2]]) &&
    (pin_change_src[2] == $past(din_next[2])))
    else $error("bit 2 routing wrong");

  a_bit1_route_map: assert property (
    analog_pin_link[1] == $past(lcd_front_plane_out[pjafm_pkg::PLANE_MAP[1]]) &&
    (pin_change_src[1] == $past(din_next[1])))
    else $error("bit 1 routing wrong");

  a_bit0_route_map: assert property (
    analog_pin_link[0] == $past(lcd_front_plane_out[pjafm_pkg::PLANE_MAP[0]]) &&
    (pin_change_src[0] == $past(din_next[0])))
    else $error("bit 0 routing wrong");

  a_upper_lcd_force: assert property (
    ctrl_reg.lcd_enable |=> (pad.drive_en[6:4] == 3'h0) && (pad.pullup_en[6:4] == 3'h0) &&
    (pad.drive_val[6:4] == $past(port_out[6:4])) && (ovr.port_value_override_enable == 7'h00))
    else $error("upper bits not forced by lcd");

  a_lower_lcd_force: assert property (
    ctrl_reg.lcd_enable |=> (pad.drive_en[3:0] == 4'h0) && (pad.pullup_en[3:0] == 4'h0) &&
    (pad.drive_val[3:0] == $past(port_out[3:0])) && ovr.direction_override_enable[0])
    else $error("lower bits not forced by lcd");

  a_input_ovr_terms: assert property (
    ovr.input_enable_override_enable == $past(mask_reg & {7{ctrl_reg.lcd_enable &
    ctrl_reg.lcd_power_mode & ctrl_reg.pin_change_group_enable_0}}))
    else $error("input override term wrong");

  a_lcd_off_plain: assert property (
    !ctrl_reg.lcd_enable |=> (pad.drive_en == $past(port_dir)) &&
    (ovr.pullup_override_enable == 7'h00) && (ovr.input_enable_override_enable == 7'h00))
    else $error("override applied with lcd off");

  a_pullup_disable: assert property (
    ctrl_reg.global_pullup_disable |=> pad.pullup_en == 7'h00)
    else $error("pull-up active while disabled");

  a_read_one_cycle: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");

endmodule

// *** verif/pjafm_far_model.sv ***
`timescale 1ns/1ns
// stand-in for the segment driver feeding the front-plane lines
module pjafm_far_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hold,
  input wire logic [39:0] pattern,
  output logic [39:0] lcd_front_plane_out
);
  // lines toggle while not held, so a stale value is never mistaken for a fresh one
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lcd_front_plane_out <= 40'h0;
    end else if (hold) begin
      lcd_front_plane_out <= pattern;
    end else begin
      lcd_front_plane_out <= ~lcd_front_plane_out;
    end
  end
endmodule

// *** verif/pjafm_mux_bench.sv ***
`timescale 1ns/1ns
module pjafm_mux_bench;
  typedef struct packed {
    pjafm_pkg::pjafm_pad_t pad;
    logic [6:0] pu_oe;
    logic [6:0] ie_oe;
    logic [6:0] link;
    logic [6:0] link_en;
    logic [6:0] din;
  } pjafm_exp_t;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [6:0] port_dir = 7'h00, port_out = 7'h00, port_input_enable = 7'h00, pad_in = 7'h00;
  logic [39:0] lcd_front_plane_out;
  logic [39:0] pattern = 40'h0;
  logic hold = 1'b0;
  logic probe = 1'b0;
  logic rd_d1 = 1'b0;
  // outputs stay unknown until the first edge applies reset, so idle read checks wait one edge
  logic armed = 1'b0;
  pjafm_pkg::pjafm_pad_t pad;
  pjafm_pkg::pjafm_ovr_t ovr;
  logic [6:0] analog_pin_link, analog_link_en, digital_in, pin_change_src;
  pjafm_exp_t exp_q[$];
  logic [7:0] rd_q[$];
  pjafm_exp_t seen_e;
  int err_total = 0;
  int samples_checked = 0;

  always #5 ref_clk = ~ref_clk;

  pjafm_mux DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_dir(port_dir),
    .port_out(port_out), .port_input_enable(port_input_enable), .pad_in(pad_in),
    .lcd_front_plane_out(lcd_front_plane_out), .pad(pad), .ovr(ovr),
    .analog_pin_link(analog_pin_link), .analog_link_en(analog_link_en),
    .digital_in(digital_in), .pin_change_src(pin_change_src));

  pjafm_far_model far (.ref_clk(ref_clk), .rst(rst), .hold(hold), .pattern(pattern),
    .lcd_front_plane_out(lcd_front_plane_out));

  task automatic check(input string what, input logic [27:0] seen, input logic [27:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
  endtask

  // watcher: read data only in the cycle after the strobe, snapshots on probe
  always @(posedge ref_clk) begin
    rd_d1 <= reg_rd;
    armed <= 1'b1;
    if (rd_d1) begin
      check("read data", reg_rdata, rd_q.pop_front());
    end else if (armed) begin
      check("idle read data", reg_rdata, 28'h0);
    end
    if (probe) begin
      seen_e = exp_q.pop_front();
      check("pad", pad, seen_e.pad); // pad control
      check("pull-up override", ovr.pullup_override_enable, seen_e.pu_oe); // lcd owns
      check("direction override", ovr.direction_override_enable, seen_e.pu_oe); // same
      check("fixed values", {ovr.pullup_override_value, ovr.direction_override_value,
        ovr.port_value_override_enable, ovr.port_value_override_value}, 28'h0); // zeros
      check("input override value", ovr.input_enable_override_value,
        rst ? 7'h00 : {7{pjafm_pkg::IE_OVR_VAL}}); // held value
      check("input override", ovr.input_enable_override_enable, seen_e.ie_oe); // four terms
      check("segment link", {analog_link_en, analog_pin_link},
        {seen_e.link_en, seen_e.link}); // line map
      check("pin inputs", {digital_in, pin_change_src},
        {seen_e.din, seen_e.din}); // source gating
    end
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    results();
  end

  initial begin
    logic [3:0] c;
    logic [6:0] m, d, o, p, q;
    logic [39:0] pat;
    logic en;
    pjafm_exp_t x;
    void'($urandom(32'hC8B8AA23));
    repeat (5) @(posedge ref_clk);
    exp_q.push_back('0);
    probe <= 1'b1;
    @(posedge ref_clk);
    probe <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 24; i++) begin
      c = 4'($urandom());
      c[pjafm_pkg::CTRL_LCD_EN_BIT] = i[0];
      if (i == 3) begin
        c = 4'hF;
      end
      m = 7'($urandom());
      d = 7'($urandom());
      o = 7'($urandom());
      p = 7'($urandom());
      q = 7'($urandom());
      pat = 40'({$urandom(), $urandom()});
      port_dir <= d;
      port_out <= o;
      port_input_enable <= p;
      pad_in <= q;
      pattern <= pat;
      hold <= 1'b1;
      bus(1'b1, 1'b0, pjafm_pkg::ADDR_CTRL, {4'h0, c});
      bus(1'b1, 1'b0, pjafm_pkg::ADDR_MASK, {1'b0, m});
      rd_q.push_back({4'h0, c});
      bus(1'b0, 1'b1, pjafm_pkg::ADDR_CTRL, 8'h00);
      rd_q.push_back({1'b0, m});
      bus(1'b0, 1'b1, pjafm_pkg::ADDR_MASK, 8'h00);
      rd_q.push_back(8'h00);
      bus(1'b0, 1'b1, 4'hF, 8'hFF);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      repeat (8) @(posedge ref_clk);
      en = c[pjafm_pkg::CTRL_LCD_EN_BIT];
      x.pad.drive_en = en ? 7'h00 : d;
      x.pad.drive_val = o;
      x.pad.pullup_en = (en | c[pjafm_pkg::CTRL_PUD_BIT]) ? 7'h00 : (~d & o);
      x.pu_oe = {7{en}};
      x.ie_oe = (en & c[pjafm_pkg::CTRL_LCD_PM_BIT] & c[pjafm_pkg::CTRL_PCG_EN0_BIT]) ? m : 7'h00;
      for (int n = 0; n < 7; n++) begin
        x.link[n] = pat[pjafm_pkg::PLANE_MAP[n]];
      end
      x.link_en = {7{en}};
      x.din = (x.ie_oe | p) & q;
      exp_q.push_back(x);
      probe <= 1'b1;
      @(posedge ref_clk);
      probe <= 1'b0;
      // status registers mirror the gated pins, the input override and the links
      rd_q.push_back({1'b0, x.din});
      bus(1'b0, 1'b1, pjafm_pkg::ADDR_PIN_STAT, 8'h00);
      rd_q.push_back({1'b0, x.ie_oe});
      bus(1'b0, 1'b1, pjafm_pkg::ADDR_OVR_STAT, 8'h00);
      rd_q.push_back({1'b0, x.link});
      bus(1'b0, 1'b1, pjafm_pkg::ADDR_LINK_STAT, 8'h00);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
      $display("test %0d done", i);
    end
    repeat (3) @(posedge ref_clk);
    results();
  end
endmodule
